// ### sync_serial_pkg.sv
// constants and types for the 8/16-bit clocked serial port
package sync_serial_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // register indices on the plain register port
  localparam logic [2:0] ADDR_SERIAL_CONTROL  = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_STATUS  = 3'h1;
  localparam logic [2:0] ADDR_LOW_DATA        = 3'h2;
  localparam logic [2:0] ADDR_HIGH_DATA       = 3'h3;
  localparam logic [2:0] ADDR_INTERRUPT_REQ   = 3'h4;
  localparam logic [2:0] ADDR_INTERRUPT_EN    = 3'h5;

  // control_status_reg field positions
  localparam int unsigned CSR_RESERVED_ONE = 7;
  localparam int unsigned CSR_OUTPUT_LEVEL = 6;
  localparam int unsigned CSR_OVERRUN      = 5;
  localparam int unsigned CSR_START_BUSY   = 0;

  // interrupt register field positions
  localparam int unsigned IRQ_DONE_BIT = 0;

  // reset values
  localparam logic [7:0] SCR_RESET   = 8'h00;
  localparam logic [7:0] CSR_RESET   = 8'h80;
  localparam logic       LEVEL_RESET = 1'b0;

  // word lengths in bits
  localparam logic [4:0] BITS_8  = 5'h08;
  localparam logic [4:0] BITS_16 = 5'h10;

  typedef struct packed {
    logic       mode_upper_bit;
    logic       mode_lower_bit;
    logic [1:0] unused;
    logic       clock_select_top_bit;
    logic [2:0] clock_select_field;
  } scr_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // half period of each internal clock, minus one, as a prescaler mask
  // selections run from phi/1024 down to phi/2
  function automatic logic [9:0] half_mask_f(input logic [2:0] sel);
    logic [9:0] m;
    m = 10'h000;
    case (sel)
      3'h0:    m = 10'h1ff;
      3'h1:    m = 10'h07f;
      3'h2:    m = 10'h01f;
      3'h3:    m = 10'h00f;
      3'h4:    m = 10'h007;
      3'h5:    m = 10'h003;
      3'h6:    m = 10'h001;
      default: m = 10'h000;
    endcase
    return m;
  endfunction

endpackage

// ### sync_serial.sv
// 8/16-bit lsb-first clocked serial port with internal or external clock
// Notes on behaviour
// [RULE_01] words of 8 or 16 bits, internal or external serial clock
// [RULE_02] clock select picks one of eight internal dividers or external clock
// [RULE_03] internal clock drives the clock pin; external clock makes it an input
// [RULE_04] mode 10 drives the selected internal clock continuously on the pin
// [RULE_05] bits go out and come in least significant first
// [RULE_06] output bit changes on each falling clock edge, held until next
// [RULE_07] input bit is sampled on each rising clock edge
// [RULE_08] with upper mode bit 0, lower mode bit selects 8 or 16 bits
// [RULE_09] any write to the serial control register restarts the sequencer
// [RULE_10] 8-bit uses low data only; 16-bit uses high and low bytes
// [RULE_11] writing 1 to start flag begins shifting data out
// [RULE_12] data shifts out and in during the same transfer
// [RULE_13] every completed transfer sets the done request flag
// [RULE_14] enable bit gates the done request onto the interrupt line
// [RULE_15] internal clock pulses only during a transfer, none after it
// [RULE_16] after a transfer the output keeps the last sent bit
// [RULE_17] external clock pulses step the shifting
// [RULE_18] external pulse while idle moves no data and sets overrun
// [RULE_19] while idle, writing output level bit changes output at once
// [RULE_20] the far master starts clocking only after start flag is set
// [RULE_21] start flag reads 1 while busy or waiting, cleared on completion
// [RULE_22] overrun cleared by reading it as 1 then writing 0
// [RULE_23] written output level holds only until next transfer shifts
// [RULE_24] internal clock makes exactly 8 or 16 pulses per transfer
//
// Chosen here: the address-and-strobe port and the placing of the registers.
module sync_serial
  import sync_serial_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  input  wire sync_serial_pkg::reg_req_t reg_req,
  output logic [7:0]                     reg_rdata,
  input  wire logic                      serial_clock_pin_in,
  output logic                           serial_clock_pin_out,
  output logic                           serial_clock_pin_oe_n,
  output logic                           serial_out_pin,
  input  wire logic                      serial_in_pin,
  output logic                           transfer_irq
);
  import sync_serial_pkg::*;

  scr_t       serial_control_reg;
  logic       busy;
  logic [4:0] bit_cnt;
  logic [15:0] shreg;
  logic       out_level;
  logic       overrun_flag;
  logic       overrun_seen;
  logic       transfer_done_request;
  logic       transfer_irq_enable;
  logic [9:0] prescale;
  logic       sck_int;
  logic       sck_s1;
  logic       sck_s2;
  logic       sck_s3;
  logic       si_s1;
  logic       si_s2;

  logic       ext_sel;
  logic       cont_mode;
  logic       xfer_mode;
  logic [4:0] word_len;
  logic       half_tick;
  logic       fall_ev;
  logic       rise_ev;
  logic       ext_rise;
  logic       ext_fall;
  logic       wr_scr;
  logic       wr_csr;
  logic       rd_csr;
  logic       start_req;
  logic       done;

  assign ext_sel   = serial_control_reg.clock_select_top_bit;
  assign cont_mode = serial_control_reg.mode_upper_bit & ~serial_control_reg.mode_lower_bit;
  assign xfer_mode = ~serial_control_reg.mode_upper_bit;
  // lower mode bit 0 means 8-bit words
  assign word_len  = serial_control_reg.mode_lower_bit ? BITS_16 : BITS_8; // [RULE_08] [RULE_01]

  assign wr_scr    = reg_req.wr && reg_req.addr == ADDR_SERIAL_CONTROL;
  assign wr_csr    = reg_req.wr && reg_req.addr == ADDR_CONTROL_STATUS;
  assign rd_csr    = reg_req.rd && reg_req.addr == ADDR_CONTROL_STATUS;
  assign start_req = wr_csr && reg_req.wdata[CSR_START_BUSY] && !busy && xfer_mode; // [RULE_11]

  // the second and third sync stages feed the edge detector
  assign ext_rise  = sck_s2 & ~sck_s3;
  assign ext_fall  = ~sck_s2 & sck_s3;
  assign half_tick = (prescale & half_mask_f(serial_control_reg.clock_select_field))
                     == half_mask_f(serial_control_reg.clock_select_field); // [RULE_02]

  always_comb begin
    if (ext_sel) begin
      fall_ev = busy && ext_fall; // [RULE_17]
      rise_ev = busy && ext_rise; // [RULE_17]
    end else begin
      fall_ev = busy && half_tick && sck_int;
      rise_ev = busy && half_tick && !sck_int;
    end
  end

  assign done = rise_ev && (bit_cnt == word_len - 5'h01);

  // pin synchronisers
  always_ff @(posedge mclk) begin
    if (srst) begin
      sck_s1 <= 1'b1;
      sck_s2 <= 1'b1;
      sck_s3 <= 1'b1;
      si_s1  <= 1'b0;
      si_s2  <= 1'b0;
    end else if (ce) begin
      if (wr_scr) begin
        // old internal-clock edges must not read as idle pulses
        sck_s1 <= 1'b1; // [RULE_09] [RULE_18]
        sck_s2 <= 1'b1;
        sck_s3 <= 1'b1;
      end else begin
        sck_s1 <= serial_clock_pin_in;
        sck_s2 <= sck_s1;
        sck_s3 <= sck_s2;
      end
      // limitation: at phi/2 and phi/4 the sync lag makes received bits stale
      si_s1  <= serial_in_pin;
      si_s2  <= si_s1;
    end
  end

  // control register; a write also resets the sequencer below
  always_ff @(posedge mclk) begin
    if (srst) begin
      serial_control_reg <= scr_t'(SCR_RESET);
    end else if (ce && wr_scr) begin
      serial_control_reg <= scr_t'(reg_req.wdata);
    end
  end

  // prescaler; restarted with the sequencer so the first half period is whole
  always_ff @(posedge mclk) begin
    if (srst) begin
      prescale <= 10'h000;
    end else if (ce) begin
      if (wr_scr || start_req) begin
        prescale <= 10'h000;
      end else begin
        prescale <= prescale + 10'h001;
      end
    end
  end

  // internal serial clock, idle high
  always_ff @(posedge mclk) begin
    if (srst) begin
      sck_int <= 1'b1;
    end else if (ce) begin
      if (wr_scr) begin
        sck_int <= 1'b1; // [RULE_09]
      end else if (!ext_sel && half_tick && (busy || cont_mode)) begin
        sck_int <= ~sck_int; // [RULE_04] [RULE_15]
      end
    end
  end

  assign serial_clock_pin_out  = sck_int;
  assign serial_clock_pin_oe_n = ext_sel; // [RULE_03]

  // busy flag and bit counter
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy    <= 1'b0;
      bit_cnt <= 5'h00;
    end else if (ce) begin
      if (wr_scr) begin
        busy    <= 1'b0; // [RULE_09]
        bit_cnt <= 5'h00;
      end else if (start_req) begin
        busy    <= 1'b1; // [RULE_21]
        bit_cnt <= 5'h00;
      end else if (done) begin
        busy    <= 1'b0; // [RULE_21] [RULE_24]
        bit_cnt <= 5'h00;
      end else if (rise_ev) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // shift register; low byte is low_data_reg, high byte high_data_reg
  always_ff @(posedge mclk) begin
    if (srst) begin
      shreg <= 16'h0000;
    end else if (ce) begin
      if (rise_ev) begin
        if (word_len == BITS_16) begin
          shreg <= {si_s2, shreg[15:1]}; // [RULE_07] [RULE_10] [RULE_12]
        end else begin
          shreg[7:0] <= {si_s2, shreg[7:1]}; // [RULE_07] [RULE_10]
        end
      end else if (reg_req.wr && reg_req.addr == ADDR_LOW_DATA) begin
        shreg[7:0] <= reg_req.wdata;
      end else if (reg_req.wr && reg_req.addr == ADDR_HIGH_DATA) begin
        shreg[15:8] <= reg_req.wdata;
      end
    end
  end

  // output level: shifted bit on falls, software level only while idle
  always_ff @(posedge mclk) begin
    if (srst) begin
      out_level <= LEVEL_RESET;
    end else if (ce) begin
      if (fall_ev) begin
        out_level <= shreg[0]; // [RULE_05] [RULE_06] [RULE_23]
      end else if (wr_csr && !busy) begin
        out_level <= reg_req.wdata[CSR_OUTPUT_LEVEL]; // [RULE_19]
      end
    end
  end

  assign serial_out_pin = out_level; // [RULE_16]

  // overrun: set wins over the read-then-write-0 clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      overrun_flag <= 1'b0;
      overrun_seen <= 1'b0;
    end else if (ce) begin
      if (ext_sel && !busy && ext_rise) begin
        overrun_flag <= 1'b1; // [RULE_18]
      end else if (wr_csr && overrun_seen && !reg_req.wdata[CSR_OVERRUN]) begin
        overrun_flag <= 1'b0; // [RULE_22]
      end
      if (rd_csr && overrun_flag) begin
        overrun_seen <= 1'b1;
      end else if (wr_csr) begin
        overrun_seen <= 1'b0;
      end
    end
  end

  // done request and its enable; hardware set beats software clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      transfer_done_request <= 1'b0;
      transfer_irq_enable   <= 1'b0;
    end else if (ce) begin
      if (done) begin
        transfer_done_request <= 1'b1; // [RULE_13]
      end else if (reg_req.wr && reg_req.addr == ADDR_INTERRUPT_REQ &&
                   !reg_req.wdata[IRQ_DONE_BIT]) begin
        transfer_done_request <= 1'b0;
      end
      if (reg_req.wr && reg_req.addr == ADDR_INTERRUPT_EN) begin
        transfer_irq_enable <= reg_req.wdata[IRQ_DONE_BIT];
      end
    end
  end

  assign transfer_irq = transfer_done_request & transfer_irq_enable; // [RULE_14]

  // read port, data one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_req.rd) begin
        case (reg_req.addr)
          ADDR_SERIAL_CONTROL: reg_rdata <= serial_control_reg;
          ADDR_CONTROL_STATUS: begin
            reg_rdata                   <= 8'h00;
            reg_rdata[CSR_RESERVED_ONE] <= 1'b1;
            reg_rdata[CSR_OUTPUT_LEVEL] <= out_level;
            reg_rdata[CSR_OVERRUN]      <= overrun_flag;
            reg_rdata[CSR_START_BUSY]   <= busy; // [RULE_21]
          end
          ADDR_LOW_DATA:       reg_rdata <= shreg[7:0];
          ADDR_HIGH_DATA:      reg_rdata <= shreg[15:8];
          ADDR_INTERRUPT_REQ:  reg_rdata <= {7'h00, transfer_done_request};
          ADDR_INTERRUPT_EN:   reg_rdata <= {7'h00, transfer_irq_enable};
          default:             reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // helper: falling edges of the serial clock, internal or external, in the current transfer
  logic [4:0] fall_cnt;
  always_ff @(posedge mclk) begin
    if (srst) begin
      fall_cnt <= 5'h00;
    end else if (ce) begin
      if (start_req || wr_scr) begin
        fall_cnt <= 5'h00;
      end else if (fall_ev) begin
        fall_cnt <= fall_cnt + 5'h01;
      end
    end
  end

  done_sets_req_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_13]
    (ce && done) |=> transfer_done_request && !busy)
    else $error("done did not set request and clear busy");

  start_busy_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_21]
    (ce && start_req && !wr_scr) |=> busy)
    else $error("start flag not reading busy");

  pulse_count_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_24]
    (done && !ext_sel) |-> fall_cnt == word_len)
    else $error("wrong pulse count in internal transfer");

  sck_idle_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_15]
    (!busy && !cont_mode && !ext_sel && !$past(busy)) |-> sck_int)
    else $error("internal clock moved while idle");

  sck_dir_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_03]
    serial_clock_pin_oe_n == serial_control_reg.clock_select_top_bit)
    else $error("clock pin direction wrong");

  lsb_first_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_06]
    (ce && fall_ev) |=> serial_out_pin == $past(shreg[0]))
    else $error("output bit not lsb of shift register");

  so_hold_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_16]
    (!busy && !wr_csr) |=> $stable(serial_out_pin))
    else $error("output moved while idle");

  sol_write_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_19]
    (ce && wr_csr && !busy) |=> serial_out_pin == $past(reg_req.wdata[CSR_OUTPUT_LEVEL]))
    else $error("output level write not applied");

  overrun_set_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_18]
    (ce && ext_sel && !busy && ext_rise && !reg_req.wr) |=> overrun_flag && $stable(shreg))
    else $error("idle pulse not flagged or moved data");

  scr_reinit_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_09]
    (ce && wr_scr) |=> !busy && bit_cnt == 5'h00 && sck_int)
    else $error("control write did not reinitialise");

  irq_gate_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_14]
    (ce && done && transfer_irq_enable &&
     !(reg_req.wr && reg_req.addr == ADDR_INTERRUPT_EN)) |=> transfer_irq)
    else $error("interrupt not gated by enable");

  busy_read_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_21]
    (ce && rd_csr) |=> reg_rdata[CSR_START_BUSY] == $past(busy))
    else $error("start flag read does not follow busy");

  overrun_keep_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_22]
    (ce && wr_csr && reg_req.wdata[CSR_OVERRUN] && overrun_flag) |=> overrun_flag)
    else $error("writing 1 cleared the overrun flag");

  overrun_clear_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_22]
    (ce && wr_csr && overrun_seen && !reg_req.wdata[CSR_OVERRUN] && !ext_rise) |=>
      !overrun_flag)
    else $error("overrun flag not cleared after read and write 0");

  byte_hold_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_10]
    (ce && rise_ev && word_len == BITS_8) |=> $stable(shreg[15:8]))
    else $error("high byte moved in 8-bit transfer");

  cont_clock_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_04]
    (ce && cont_mode && !ext_sel && half_tick && !wr_scr) |=>
      serial_clock_pin_out != $past(serial_clock_pin_out))
    else $error("continuous clock did not toggle");

  no_start_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_11]
    (ce && !xfer_mode && !busy && !wr_scr) |=> !busy)
    else $error("transfer started outside transfer mode");

  ext_step_a: assert property (@(posedge mclk) disable iff (srst) // [RULE_17]
    (ce && ext_sel && rise_ev && !done && !wr_scr) |=> bit_cnt == $past(bit_cnt) + 5'h01)
    else $error("external pulse did not step the bit counter");

endmodule

// ### serial_peer.sv
// behavioural far-side peer for the clocked serial port
module serial_peer (
  input  wire logic mclk,
  input  wire logic sck,
  input  wire logic sdo,
  output logic      sdi = 1'b0,
  output logic      sck_drv = 1'b1,
  output logic      sck_en = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] tx = '0;
  logic [15:0] rx = '0;
  int          nb = 8;
  int          fi = 0;
  int          ri = 0;

  // next word to send; bit counters restart
  task automatic load(input logic [15:0] w, input int n);
    tx = w;
    nb = n;
    fi = 0;
    ri = 0;
  endtask

  // external master: clock idles high between frames
  task automatic pulses(input int n, input int half);
    sck_en <= 1'b1;
    repeat (n) begin
      repeat (half) @(posedge mclk);
      sck_drv <= 1'b0;
      repeat (half) @(posedge mclk);
      sck_drv <= 1'b1;
    end
    repeat (half) @(posedge mclk);
    sck_en <= 1'b0;
  endtask

  // lsb first, one bit per falling edge, held until the next
  always @(negedge sck) begin
    if (fi < nb) begin
      sdi <= tx[fi];
    end
    fi++;
  end

  // sample on rising edge; after the last bit the line stops holding
  always @(posedge sck) begin
    rx <= {sdo, rx[15:1]};
    ri++;
    if (ri == nb) begin
      repeat (4) @(posedge mclk);
      sdi <= ~sdi;
    end
  end
endmodule

// ### sync_serial_tb_top.sv
// self-checking bench for the clocked serial port
module sync_serial_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sync_serial_pkg::*;

  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  reg_req_t   reg_req = '0;
  logic [7:0] reg_rdata;
  logic       sck, sck_out, oe_n, sdo, sdi, sck_drv, sck_en, irq;
  logic       sck_q = 1'b1;
  logic [7:0] d;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         falls = 0;
  int         gap = 0;
  int         last_fall = 0;
  int         half_tab [8] = '{512, 128, 32, 16, 8, 4, 2, 1};

  always #5 mclk = ~mclk;

  // clock pin carries a pull-up when nobody drives it
  assign sck = !oe_n ? sck_out : (sck_en ? sck_drv : 1'b1);

  sync_serial i_dut (
    .mclk                  (mclk),
    .srst                  (srst),
    .ce                    (1'b1),
    .reg_req               (reg_req),
    .reg_rdata             (reg_rdata),
    .serial_clock_pin_in   (sck),
    .serial_clock_pin_out  (sck_out),
    .serial_clock_pin_oe_n (oe_n),
    .serial_out_pin        (sdo),
    .serial_in_pin         (sdi),
    .transfer_irq          (irq)
  );

  serial_peer i_peer (
    .mclk    (mclk),
    .sck     (sck),
    .sdo     (sdo),
    .sdi     (sdi),
    .sck_drv (sck_drv),
    .sck_en  (sck_en)
  );

  // falling edges of the pin and the spacing of the last two; hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    sck_q <= sck;
    if (sck_q && !sck) begin
      falls <= falls + 1;
      gap <= cyc - last_fall;
      last_fall <= cyc;
    end
    if (cyc > 60000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge mclk);
    reg_req <= '0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    reg_req <= '0;
    #1;
    v = reg_rdata;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp);
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  // poll busy; bounded so a stuck flag fails the check below
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(ADDR_CONTROL_STATUS, d);
      n++;
    end while (d[0] !== 1'b0 && n < 10000);
    chk({15'h0000, d[0]}, 16'h0000);
  endtask

  task automatic go(input logic [7:0] csr);
    falls = 0;
    wr(ADDR_CONTROL_STATUS, csr);
    wait_idle();
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    chk_rd(ADDR_CONTROL_STATUS, CSR_RESET);
    chk(16'({oe_n, sck_out, sdo, irq}), 16'h4);
    chk_rd(3'h6, 8'h00);
    wr(ADDR_CONTROL_STATUS, 8'h40);
    chk(16'(sdo), 16'h1);
    chk_rd(ADDR_CONTROL_STATUS, 8'hc0);
    // 8-bit full duplex on internal clock, level 1 overridden by bit 0
    wr(ADDR_SERIAL_CONTROL, 8'h04);
    wr(ADDR_LOW_DATA, 8'ha4);
    wr(ADDR_INTERRUPT_EN, 8'h01);
    i_peer.load(16'h003c, 8);
    falls = 0;
    wr(ADDR_CONTROL_STATUS, 8'h41);
    chk_rd(ADDR_CONTROL_STATUS, 8'hc1);
    wait (falls == 1);
    repeat (2) @(posedge mclk);
    chk(16'(sdo), 16'h0);
    wait_idle();
    chk(16'(falls), 16'h8);
    chk(16'(gap), 16'd16);
    chk({8'h00, i_peer.rx[15:8]}, 16'h00a4);
    chk_rd(ADDR_LOW_DATA, 8'h3c);
    chk(16'(sdo), 16'h1);
    chk(16'(irq), 16'h1);
    repeat (100) @(posedge mclk);
    chk(16'(falls), 16'h8);
    wr(ADDR_INTERRUPT_REQ, 8'h00);
    chk(16'(irq), 16'h0);
    // 16-bit word with the request masked
    wr(ADDR_INTERRUPT_EN, 8'h00);
    wr(ADDR_SERIAL_CONTROL, 8'h44);
    wr(ADDR_HIGH_DATA, 8'h12);
    wr(ADDR_LOW_DATA, 8'h34);
    i_peer.load(16'hbeef, 16);
    go(8'h01);
    chk(16'(falls), 16'h10);
    chk(i_peer.rx, 16'h1234);
    chk_rd(ADDR_HIGH_DATA, 8'hbe);
    chk_rd(ADDR_LOW_DATA, 8'hef);
    chk(16'(irq), 16'h0);
    chk_rd(ADDR_INTERRUPT_REQ, 8'h01);
    // every internal divider in 8-bit mode
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_SERIAL_CONTROL, 8'(s));
      i_peer.load(16'h0000, 8);
      go(8'h01);
      chk(16'(falls), 16'h8);
      chk(16'(gap), 16'(2 * half_tab[s]));
    end
    falls = 0;
    wr(ADDR_SERIAL_CONTROL, 8'h86);
    repeat (40) @(posedge mclk);
    chk(16'(falls >= 8), 16'h1);
    chk(16'(oe_n), 16'h0);
    wr(ADDR_CONTROL_STATUS, 8'h01);
    chk_rd(ADDR_CONTROL_STATUS, 8'h80);
    // external clock: aborted frame, full frame, then a surplus pulse
    wr(ADDR_SERIAL_CONTROL, 8'h08);
    chk(16'(oe_n), 16'h1);
    wr(ADDR_LOW_DATA, 8'h5a);
    wr(ADDR_CONTROL_STATUS, 8'h01);
    i_peer.pulses(3, 6);
    wr(ADDR_SERIAL_CONTROL, 8'h08);
    rd(ADDR_CONTROL_STATUS, d);
    chk(16'(d[0]), 16'h0);
    wr(ADDR_LOW_DATA, 8'h5a);
    i_peer.load(16'h00c3, 8);
    wr(ADDR_CONTROL_STATUS, 8'h01);
    i_peer.pulses(8, 6);
    wait_idle();
    chk({8'h00, i_peer.rx[15:8]}, 16'h005a);
    chk_rd(ADDR_LOW_DATA, 8'hc3);
    chk_rd(ADDR_CONTROL_STATUS, 8'h80);
    i_peer.pulses(1, 6);
    repeat (4) @(posedge mclk);
    chk_rd(ADDR_LOW_DATA, 8'hc3);
    chk_rd(ADDR_CONTROL_STATUS, 8'ha0);
    wr(ADDR_CONTROL_STATUS, 8'h20);
    chk_rd(ADDR_CONTROL_STATUS, 8'ha0);
    wr(ADDR_CONTROL_STATUS, 8'h00);
    chk_rd(ADDR_CONTROL_STATUS, 8'h80);
    end_sim();
  end
endmodule
